// ===== src/pdc_pkg.sv
// package: register map, field layout and constants of the pll divider and clock output block
package pdc_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 10;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h03d;
  localparam logic [IDX_W-1:0] IDX_ODIV = 10'h03e;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h030;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned SEL_LSB = 4;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned EN_BIT = 3;
  localparam int unsigned PD_BIT = 2;
  localparam int unsigned FB_LSB = 0;
  localparam int unsigned FB_W = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ODIV_RESET = 8'h08;

  // ----------------------------------------------------------------
  // clock output select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_IO = 4'h0;
  localparam logic [3:0] SEL_PLL = 4'h1;
  localparam logic [3:0] SEL_LOW = 4'h2;
  localparam logic [3:0] SEL_HIGH = 4'h3;
  localparam logic [3:0] SEL_XTAL1 = 4'h4;
  localparam logic [3:0] SEL_XTAL2 = 4'h5;
  localparam logic [3:0] SEL_XTAL4 = 4'h6;
  localparam logic [3:0] SEL_XTAL8 = 4'h7;
  localparam logic [3:0] SEL_TMR0 = 4'h8;
  localparam logic [3:0] SEL_TMR1 = 4'h9;
  localparam logic [3:0] SEL_TMR2 = 4'ha;
  localparam logic [3:0] SEL_TMR3 = 4'hb;

  // ----------------------------------------------------------------
  // pll factors
  // ----------------------------------------------------------------
  localparam logic [4:0] FB_FACTOR_0 = 5'h17; // 23
  localparam logic [4:0] FB_FACTOR_1 = 5'h1b; // 27
  localparam logic [4:0] FB_FACTOR_2 = 5'h1c; // 28
  localparam logic [4:0] FB_FACTOR_3 = 5'h17; // 23
  localparam logic [7:0] ODIV_MIN = 8'h08;

  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== src/pdc_top.sv
// module: clock output select, pll divider control and their axi4-lite register file
//
// What this block does
// - select code 0h releases the clock output pin to general I/O.
// - select code 1h drives the pin with the pll clock result.
// - code 2h holds the pin low, code 3h holds it high.
// - code 4h puts the undivided crystal reference on the pin.
// - codes 5h, 6h, 7h put crystal divided by 2, 4, 8 on pin.
// - codes 8h to Bh toggle the pin on timer zero to three overflow.
// - control bit 3 enables the selected clock onto the pin.
// - feedback code picks factor 23, 27, 28 or 23.
// - output divider values 0 to 7 are reserved, no defined clock.
// - output divider values 8 to 255 divide by exactly that value.
// - first stage multiplies the reference by the factor and halves it.
// - second stage divides first stage by the output divider value.
`timescale 1ns/1ps
module pdc_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [pdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [pdc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [pdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [pdc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // crystal reference and analog pll
  input wire logic xtal_ref,
  input wire logic pll_stage1_clk,
  output logic [4:0] pll_feedback_factor,
  output logic pll_powerdown,
  // timer overflow pulses, core clock domain
  input wire logic timer_zero,
  input wire logic timer_one,
  input wire logic timer_two,
  input wire logic timer_three,
  // general I/O drive used when the pin is released
  input wire logic io_out,
  input wire logic io_oe,
  // clock output pin
  input wire logic clock_output_pin_in,
  output logic clock_output_pin_out,
  output logic clock_output_pin_oe,
  output logic clock_output_pin_sync
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // software visible registers
    logic [7:0] ctrl;
    logic [7:0] odiv;
    // write channel holding state
    logic aw_got;
    logic [pdc_pkg::IDX_W-1:0] aw_idx;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    // read channel answer
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    // synchronisers; a third stage feeds the edge detectors
    logic xt1;
    logic xt2;
    logic xt3;
    logic pl1;
    logic pl2;
    logic pl3;
    logic io1;
    logic io2;
    // dividers and timer toggle
    logic [2:0] xdiv;
    logic [7:0] pcnt;
    logic pll_res;
    logic tmr_tgl;
    // registered pin drive
    logic pin_out;
    logic pin_oe;
  } pdc_state_s;

  pdc_state_s s;
  pdc_state_s next_s;

  // ----------------------------------------------------------------
  // decoded fields
  // ----------------------------------------------------------------
  // register fields
  logic [3:0] clock_output_select;
  logic clock_output_enable;
  logic pll_powerdown_bit;
  logic [1:0] fb_code;
  logic [7:0] pll_output_factor;

  // edge strobes and divider helpers
  logic xtal_rise;
  logic pll_rise;
  logic odiv_legal;
  logic [7:0] half_div;

  // selection results and status word
  logic tmr_event;
  logic sel_out;
  logic [7:0] status_val;

  // field extraction from the control and divider registers
  assign clock_output_select = s.ctrl[pdc_pkg::SEL_LSB +: pdc_pkg::SEL_W];
  assign clock_output_enable = s.ctrl[pdc_pkg::EN_BIT];
  assign pll_powerdown_bit = s.ctrl[pdc_pkg::PD_BIT];
  assign fb_code = s.ctrl[pdc_pkg::FB_LSB +: pdc_pkg::FB_W];
  assign pll_output_factor = s.odiv;

  // divider helpers; values under eight are refused rather than guessed at
  assign odiv_legal = (pll_output_factor >= pdc_pkg::ODIV_MIN);
  assign half_div = {1'b0, s.odiv[7:1]};
  // edges are taken from the second and third stages, never the first
  assign xtal_rise = s.xt2 & ~s.xt3;
  assign pll_rise = s.pl2 & ~s.pl3;

  // status word: timer toggle, pin drive, pll result, pin readback
  assign status_val = {4'h0, s.tmr_tgl, s.pin_out, s.pll_res, s.io2};

  // ----------------------------------------------------------------
  // handshake and analog control outputs
  // ----------------------------------------------------------------
  // write channel, ready while nothing is held
  assign s_axi_awready = ~s.aw_got;
  assign s_axi_wready = ~s.w_got;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;

  // read channel, one read at a time since arready falls while rvalid stands
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h000000, s.rdata};

  // analog controls and pin
  assign pll_powerdown = pll_powerdown_bit;
  assign clock_output_pin_out = s.pin_out;
  assign clock_output_pin_oe = s.pin_oe;
  assign clock_output_pin_sync = s.io2;

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // feedback factor presented to the analog multiplier, which halves its product
  // codes 0 and 3 share the same factor
  always_comb begin
    unique case (fb_code)
      2'h0: pll_feedback_factor = pdc_pkg::FB_FACTOR_0;
      2'h1: pll_feedback_factor = pdc_pkg::FB_FACTOR_1;
      2'h2: pll_feedback_factor = pdc_pkg::FB_FACTOR_2;
      2'h3: pll_feedback_factor = pdc_pkg::FB_FACTOR_3;
    endcase
  end

  // timer overflow chosen by the select code, others are ignored
  always_comb begin
    unique case (clock_output_select)
      pdc_pkg::SEL_TMR0: tmr_event = timer_zero;
      pdc_pkg::SEL_TMR1: tmr_event = timer_one;
      pdc_pkg::SEL_TMR2: tmr_event = timer_two;
      pdc_pkg::SEL_TMR3: tmr_event = timer_three;
      default: tmr_event = 1'b0;
    endcase
  end

  // level that the selected source puts on the pin
  always_comb begin
    unique case (clock_output_select)
      pdc_pkg::SEL_IO: sel_out = io_out;
      // power-down forces the pll path low before the divider has parked
      pdc_pkg::SEL_PLL: sel_out = s.pll_res & ~pll_powerdown_bit;
      pdc_pkg::SEL_LOW: sel_out = 1'b0;
      pdc_pkg::SEL_HIGH: sel_out = 1'b1;
      pdc_pkg::SEL_XTAL1: sel_out = s.xt3;
      pdc_pkg::SEL_XTAL2: sel_out = s.xdiv[0];
      pdc_pkg::SEL_XTAL4: sel_out = s.xdiv[1];
      pdc_pkg::SEL_XTAL8: sel_out = s.xdiv[2];
      pdc_pkg::SEL_TMR0,
      pdc_pkg::SEL_TMR1,
      pdc_pkg::SEL_TMR2,
      pdc_pkg::SEL_TMR3: sel_out = s.tmr_tgl;
      // reserved codes Ch to Fh: pin held low as a safe choice
      default: sel_out = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // synchronisers: crystal, pll first stage and pin readback
    // a metastable first stage is only ever read by the second
    next_s.xt1 = xtal_ref;
    next_s.xt2 = s.xt1;
    next_s.xt3 = s.xt2;
    next_s.pl1 = pll_stage1_clk;
    next_s.pl2 = s.pl1;
    next_s.pl3 = s.pl2;
    next_s.io1 = clock_output_pin_in;
    next_s.io2 = s.io1;

    // crystal ladder: bit n toggles every 2^n crystal periods, a period of 2^(n+1)
    // limitation: the crystal is sampled, so the pin carries core clock jitter
    if (xtal_rise) begin
      next_s.xdiv = s.xdiv + 3'h1;
    end

    // second stage divider, stopped at power-down or for reserved values
    // parking the counter keeps a partial period from escaping
    if (pll_powerdown_bit || !odiv_legal) begin
      next_s.pcnt = 8'h00;
      next_s.pll_res = 1'b0;
    end else if (pll_rise) begin
      // one period spans exactly odiv first-stage edges
      // high for the first half, so odd values give a shorter high phase
      if (s.pcnt >= pll_output_factor - 8'h01) begin
        next_s.pcnt = 8'h00;
      end else begin
        next_s.pcnt = s.pcnt + 8'h01;
      end
      next_s.pll_res = (next_s.pcnt < half_div);
    end

    // timer toggle, cleared while a timer code is not selected
    // clearing it gives a known low start when a timer code is chosen
    if (clock_output_select[3:2] != 2'h2) begin
      next_s.tmr_tgl = 1'b0;
    end else if (tmr_event) begin
      next_s.tmr_tgl = ~s.tmr_tgl;
    end

    // pin drive: released for I/O, otherwise gated by the enable bit
    // the enable gates the level, not oe, so a disabled pin is held low
    if (clock_output_select == pdc_pkg::SEL_IO) begin
      next_s.pin_out = io_out;
      next_s.pin_oe = io_oe;
    end else begin
      next_s.pin_out = sel_out & clock_output_enable;
      next_s.pin_oe = 1'b1;
    end

    // write address and data are taken in either order
    // only byte lane 0 carries the 8-bit registers, upper lanes are ignored
    if (s_axi_awvalid && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.aw_idx = s_axi_awaddr[pdc_pkg::ADDR_W-1:2];
    end
    if (s_axi_wvalid && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.w_byte = s_axi_wdata[7:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end

    // commit a write once both halves are held and no response is pending
    // a pending response holds the next commit back until bready; one more address and data can still be taken
    // status writes are accepted and ignored, other unmapped indices error
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = pdc_pkg::RESP_OKAY;
      if (s.aw_idx == pdc_pkg::IDX_CTRL) begin
        if (s.w_lane0) begin
          next_s.ctrl = s.w_byte;
        end
      end else if (s.aw_idx == pdc_pkg::IDX_ODIV) begin
        if (s.w_lane0) begin
          next_s.odiv = s.w_byte;
        end
      end else if (s.aw_idx != pdc_pkg::IDX_STATUS) begin
        next_s.bresp = pdc_pkg::RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // read: answer one cycle after the address is taken
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = pdc_pkg::RESP_OKAY;
      unique case (s_axi_araddr[pdc_pkg::ADDR_W-1:2])
        pdc_pkg::IDX_CTRL: next_s.rdata = s.ctrl;
        pdc_pkg::IDX_ODIV: next_s.rdata = s.odiv;
        pdc_pkg::IDX_STATUS: next_s.rdata = status_val;
        // unmapped read answers zero with an error
        default: begin
          next_s.rdata = 8'h00;
          next_s.rresp = pdc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // synchronous reset; all state is constant under it
    // it stands last so that it overrides every update above
    if (!rst_n) begin
      next_s = '0;
      next_s.ctrl = pdc_pkg::CTRL_RESET;
      next_s.odiv = pdc_pkg::ODIV_RESET;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // one register stage for the whole struct, reset is folded into next_s
  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

endmodule

// ===== bench/pdc_checker.sv
// checker: bus timing, pin source and pll control properties of the clock output block
`timescale 1ns/1ps
module pdc_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // write address, data and response
  input wire logic [pdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [pdc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  // read address and data
  input wire logic [pdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [pdc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pll controls and timer overflows
  input wire logic [4:0] pll_feedback_factor,
  input wire logic pll_powerdown,
  input wire logic timer_zero,
  input wire logic timer_one,
  input wire logic timer_two,
  input wire logic timer_three,
  // general I/O drive and clock output pin
  input wire logic io_out,
  input wire logic io_oe,
  input wire logic clock_output_pin_out,
  input wire logic clock_output_pin_oe
);
  // --------------------------------------------------------------
  // shadow registers
  // --------------------------------------------------------------
  logic [11:0] sh_a;
  logic [7:0] sh_d, ctl, odv;
  logic sh_s, ha, hw;
  logic [3:0] sel, tmr;
  logic [4:0] fac;
  logic tsel;
  assign sel = ctl[7:4];
  assign tmr = {timer_three, timer_two, timer_one, timer_zero};
  assign tsel = sel[3:2] == 2'h2 && tmr[sel[1:0]];
  assign fac = ctl[1:0] == 2'h1 ? 5'h1b : (ctl[1:0] == 2'h2 ? 5'h1c : 5'h17);
  // commit one edge after both halves arrive, the same edge the block updates on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ha <= 1'b0;
      hw <= 1'b0;
      ctl <= pdc_pkg::CTRL_RESET;
      odv <= pdc_pkg::ODIV_RESET;
    end else if (ha && hw) begin
      ha <= 1'b0;
      hw <= 1'b0;
      if (sh_s && sh_a[11:2] == pdc_pkg::IDX_CTRL) ctl <= sh_d;
      if (sh_s && sh_a[11:2] == pdc_pkg::IDX_ODIV) odv <= sh_d;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        sh_a <= s_axi_awaddr;
        ha <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        sh_d <= s_axi_wdata[7:0];
        sh_s <= s_axi_wstrb[0];
        hw <= 1'b1;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_FB: assert property (pll_feedback_factor == fac)
    else $error("feedback factor differs from control code");
  AST_PD: assert property (pll_powerdown == ctl[2])
    else $error("power-down output differs from control bit");
  AST_IO: assert property (sel == 4'h0 |=> clock_output_pin_out == $past(io_out)
    && clock_output_pin_oe == $past(io_oe)) else $error("released pin not following io");
  AST_LOW: assert property (sel == 4'h2 |=> clock_output_pin_oe && !clock_output_pin_out)
    else $error("pin not held low");
  AST_HIGH: assert property (sel == 4'h3 && ctl[3] |=> clock_output_pin_out)
    else $error("pin not held high");
  AST_GATE: assert property (sel != 4'h0 && !ctl[3] |=> !clock_output_pin_out)
    else $error("pin active while disabled");
  AST_TMR: assert property (ctl[3] && tsel |-> ##[1:3] $changed(clock_output_pin_out))
    else $error("pin did not toggle on timer overflow");
  AST_PLL0: assert property ((sel == 4'h1 && (ctl[2] || odv < 8'h08))[*3]
    |-> !clock_output_pin_out) else $error("pll output active while stopped");
  AST_BV: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_UNMAP: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[11:2] != pdc_pkg::IDX_CTRL && s_axi_araddr[11:2] != pdc_pkg::IDX_ODIV
    && s_axi_araddr[11:2] != pdc_pkg::IDX_STATUS |=> s_axi_rvalid
    && s_axi_rresp == pdc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  cover property (ctl[3] && tsel);
  cover property (sel == 4'h1 && ctl[3] && clock_output_pin_out);
  cover property (s_axi_rvalid && s_axi_rresp == pdc_pkg::RESP_SLVERR);
endmodule
bind pdc_top pdc_checker u_chk (.*);

// ===== bench/test_pll_divider_clock_output_select.sv
// testbench: register access, pin source selection and pll divider of the clock output block
`timescale 1ns/1ps
module test_pll_divider_clock_output_select;
  // --------------------------------------------------------------
  // stimulus and rows
  // --------------------------------------------------------------
  localparam logic [11:0] A_CTL = {pdc_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_DIV = {pdc_pkg::IDX_ODIV, 2'h0};
  // row: control byte, factor, power-down, pin level, pin enable (io_out 1, io_oe 0)
  localparam logic [15:0] ROWS [5] = '{{8'h00, 5'h17, 3'h2}, {8'h29, 5'h1b, 3'h1},
    {8'h3a, 5'h1c, 3'h3}, {8'h37, 5'h17, 3'h5}, {8'h1c, 5'h17, 3'h5}};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pwd, pin_sync;
  logic [1:0] bresp, rresp, r;
  logic [4:0] fac;
  logic [3:0] tmr = 4'h0;
  logic xtal = 1'b0, st1 = 1'b0, io_out = 1'b1, io_oe = 1'b0, pin_in = 1'b1;
  int cyc = 0, error_cnt = 0, n_compared = 0, c;
  pdc_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .xtal_ref(xtal), .pll_stage1_clk(st1), .pll_feedback_factor(fac),
    .pll_powerdown(pwd), .timer_zero(tmr[0]), .timer_one(tmr[1]), .timer_two(tmr[2]),
    .timer_three(tmr[3]), .io_out(io_out), .io_oe(io_oe), .clock_output_pin_in(pin_in),
    .clock_output_pin_out(pin_out), .clock_output_pin_oe(pin_oe), .clock_output_pin_sync(pin_sync)
  );
  always #4 core_clk = ~core_clk;
  // crystal period 8 cycles, stage one period 4 cycles; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    xtal <= cyc[2];
    st1 <= cyc[1];
    pin_in <= pin_oe ? pin_out : 1'b1;
    if (cyc == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // address and data offered together, each dropped once its ready is seen
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // waits for the answer; only the cycle ceiling ends a hang
    forever begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // one edge of slack either way, since the window start is not phase aligned
  task automatic cnt(input int e);
    logic p;
    c = 0;
    p = pin_out;
    repeat (256) begin
      @(posedge core_clk);
      if (pin_out && !p) c++;
      p = pin_out;
    end
    chk("rising edges", e, (c >= e - 1 && c <= e + 1) ? e : c);
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    tmr[k] <= 1'b1;
    @(posedge core_clk);
    tmr[k] <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(A_CTL);
    chk("ctrl reset", pdc_pkg::CTRL_RESET, d);
    rd(A_DIV);
    chk("odiv reset", pdc_pkg::ODIV_RESET, d);
    foreach (ROWS[i]) begin
      wr(A_CTL, ROWS[i][15:8]);
      repeat (4) @(posedge core_clk);
      chk("pins", ROWS[i][7:0], {fac, pwd, pin_out, pin_oe});
      chk("pin readback sync", ROWS[i][1], pin_sync);
      rd(A_CTL);
      chk("ctrl readback", ROWS[i][15:8], d);
    end
    rd(12'h000);
    chk("unmapped read", {pdc_pkg::RESP_SLVERR, 30'h0}, {r, d[29:0]});
    wr(12'h004, 8'h55);
    chk("unmapped write", pdc_pkg::RESP_SLVERR, r);
    wr(A_DIV, 8'hff);
    rd(A_DIV);
    chk("odiv readback", 8'hff, d);
    for (int k = 0; k < 4; k++) begin
      wr(A_CTL, {4'h4 + 4'(k), 4'h8});
      cnt(32 >> k);
    end
    wr(A_CTL, 8'h18);
    wr(A_DIV, 8'h08);
    cnt(8);
    wr(A_DIV, 8'h10);
    cnt(4);
    wr(A_CTL, 8'h1c);
    cnt(0);
    wr(A_CTL, 8'h18);
    cnt(4);
    wr(A_DIV, 8'h07);
    cnt(0);
    chk("reserved divider pin", 1'b0, pin_out);
    for (int k = 0; k < 4; k++) begin
      wr(A_CTL, {4'h8 + 4'(k), 4'h8});
      repeat (3) @(posedge core_clk);
      d = {31'h0, pin_out};
      pulse((k + 1) % 4);
      chk("other timer", d[0], pin_out);
      pulse(k);
      chk("own timer", !d[0], pin_out);
    end
    // reset in mid-run: pin and registers return to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("pin after reset", 2'h0, {pin_out, pin_oe});
    rd(A_CTL);
    chk("ctrl after reset", pdc_pkg::CTRL_RESET, d);
    rd(A_DIV);
    chk("odiv after reset", pdc_pkg::ODIV_RESET, d);
    give_verdict();
  end
endmodule
